// ==== design/sesv_top.sv ====
// External status latching and interrupt vector formation for one serial channel
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/1ps
module sesv_top #(
    parameter int CHANNEL_A = 1
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [sesv_pkg::ADDR_W-1:0] addr_i,
    input wire logic [sesv_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [sesv_pkg::DATA_W-1:0] rdata_o,
    input wire logic cts_b_i,
    input wire logic dcd_b_i,
    input wire logic sync_b_i,
    input wire logic rx_bit_valid_i,
    input wire logic rx_bit_i,
    input wire logic rx_char_valid_i,
    input wire logic rx_break_char_i,
    input wire logic rx_addr_valid_i,
    input wire logic [sesv_pkg::DATA_W-1:0] rx_addr_i,
    input wire logic sync_det_i,
    input wire logic tx_data_write_i,
    input wire logic tx_buf_empty_i,
    input wire logic tx_shift_empty_i,
    input wire logic tx_underrun_i,
    input wire logic send_abort_i,
    input wire logic transmit_baud_generator_zero_i,
    input wire logic receive_baud_generator_zero_i,
    input wire logic tx_empty_int_i,
    input wire logic rx_avail_int_i,
    input wire logic special_rx_int_i,
    output logic rx_data_valid_o,
    output logic tx_send_crc_o,
    output logic es_int_o
);
    import sesv_pkg::*;

    initial begin
        if (CHANNEL_A != 0 && CHANNEL_A != 1) begin
            $error("CHANNEL_A must be 0 or 1");
        end
    end

    // --------------------------------------------------------------
    // State
    // --------------------------------------------------------------
    typedef struct packed {
        logic master;
        logic [7:0] ie;
        logic [7:0] rxctl;
        logic [7:0] station;
        logic crystal;
        logic [7:0] vmode;
        logic [7:0] pvec;
        logic [7:0] mode;
        logic [7:0] held;
        logic [7:0] frozen;
        logic pend;
        logic brk;
        logic armed;
        logic srch;
        logic abga;
        logic end_of_message;
        logic hunt;
        logic allsent;
        logic txz;
        logic rxz;
        logic first_wr;
        logic crc;
        logic [7:0] rdata;
    } sesv_state_s;

    sesv_state_s s;
    sesv_state_s next_s;

    logic det_abort;
    logic det_idle;
    logic det_flag;
    logic det_ga;
    logic det_zero;

    sesv_run_det #(
        .RUN_W(4)
    ) u_det (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .bit_valid_i(rx_bit_valid_i),
        .bit_i(rx_bit_i),
        .abort_o(det_abort),
        .idle_o(det_idle),
        .flag_o(det_flag),
        .ga_o(det_ga),
        .zero_o(det_zero)
    );

    // --------------------------------------------------------------
    // Mode decode and live conditions
    // --------------------------------------------------------------
    logic is_async;
    logic is_bop;
    logic is_loop;
    logic pin_sync;
    logic [7:0] cur;
    logic [7:0] shown;
    logic [7:0] vec;
    logic [7:0] latch_en;
    logic [1:0] cause;
    logic [2:0] field;

    assign is_async = (s.mode[1:0] == MODE_ASYNC);
    assign is_bop = (s.mode[1:0] == MODE_BOP);
    assign is_loop = is_bop & s.mode[LM_LOOP];
    assign pin_sync = is_async | ((s.mode[1:0] == MODE_COP) & s.mode[LM_EXT_SYNC]);

    always_comb begin
        cur = RESET_BYTE;
        cur[B_BRK] = is_async ? s.brk : (is_bop & s.abga);
        cur[B_EOM] = s.end_of_message;
        cur[B_CTS] = ~cts_b_i;
        cur[B_SYNC] = pin_sync ? ~sync_b_i : s.hunt;
        cur[B_DCD] = ~dcd_b_i;
        cur[B_ALLSENT] = s.allsent;
        cur[B_IDLE] = is_bop & det_idle;
        cur[B_BRG] = s.txz | s.rxz;
    end

    // Crystal use turns the sync pin into an oscillator input, so it may not interrupt
    always_comb begin
        latch_en = {8{s.master}} & s.ie;
        latch_en[B_SYNC] = latch_en[B_SYNC] & ~(pin_sync & s.crystal);
    end

    assign shown = (s.frozen & s.held) | (~s.frozen & cur);

    // --------------------------------------------------------------
    // Vector formation
    // --------------------------------------------------------------
    always_comb begin
        if (special_rx_int_i) begin
            cause = CAUSE_SPECIAL_RX;
        end else if (rx_avail_int_i) begin
            cause = CAUSE_RX_AVAIL;
        end else if (s.pend) begin
            cause = CAUSE_EXT_STATUS;
        end else begin
            cause = CAUSE_TX_EMPTY;
        end
        field = {CHANNEL_A[0], cause};
        if (!s.vmode[VMC_STATUS_VEC]) begin
            vec = s.pvec;
        end else if (s.vmode[VMC_TYPE_B]) begin
            vec = {s.pvec[7:3], field};
        end else begin
            vec = {s.pvec[7:5], field, s.pvec[1:0]};
        end
    end

    // --------------------------------------------------------------
    // Next state
    // --------------------------------------------------------------
    logic wr_mode;
    logic wr_rxc;
    logic wr_cmd;
    logic tx_en_new;
    logic tx_on;
    logic tx_off;
    logic rx_en_new;
    logic rx_off;
    logic cmd_eom;
    logic cmd_latch;
    logic abort_ok;
    logic eom_set;
    logic eom_clr;
    logic [7:0] trig;
    logic [7:0] base_frz;

    always_comb begin
        next_s = s;
        wr_mode = wr_i & (addr_i == OFF_LINE_MODE);
        wr_rxc = wr_i & (addr_i == OFF_RECEIVE_CONTROL);
        wr_cmd = wr_i & (addr_i == OFF_COMMAND_CONTROL);
        tx_en_new = wr_mode ? wdata_i[LM_TX_EN] : s.mode[LM_TX_EN];
        tx_on = tx_en_new & ~s.mode[LM_TX_EN];
        tx_off = ~tx_en_new & s.mode[LM_TX_EN];
        rx_en_new = wr_rxc ? wdata_i[RXC_ENABLE] : s.rxctl[RXC_ENABLE];
        rx_off = ~rx_en_new & s.rxctl[RXC_ENABLE];
        cmd_eom = wr_cmd & (wdata_i[7:6] == CMD_RESET_EOM);
        cmd_latch = wr_cmd & (wdata_i[5:3] == CMD_RESET_LATCH);

        if (wr_i) begin
            case (addr_i)
                OFF_INTERRUPT_MODE_CONTROL: next_s.master = wdata_i[IMC_MASTER];
                OFF_STATUS_INTERRUPT_ENABLES: next_s.ie = wdata_i;
                OFF_RECEIVE_CONTROL: next_s.rxctl = wdata_i;
                OFF_STATION_ADDRESS: next_s.station = wdata_i;
                OFF_CLOCK_SOURCE_CONTROL: next_s.crystal = wdata_i[CSC_CRYSTAL];
                OFF_VECTOR_MODE_CONTROL: next_s.vmode = wdata_i;
                OFF_PROGRAMMED_VECTOR: next_s.pvec = wdata_i;
                OFF_LINE_MODE: next_s.mode = wdata_i;
                default: next_s.master = s.master;
            endcase
        end

        // Break: a one on the line ends it, a fresh break character wins
        next_s.brk = (s.brk & ~(rx_bit_valid_i & rx_bit_i)) | rx_break_char_i;

        // Abort arming by the first flag after receive enable
        if (!rx_en_new) begin
            next_s.armed = 1'b0;
        end else if (det_flag) begin
            next_s.armed = 1'b1;
        end
        // Address search lasts for one match; a new write re-arms it
        next_s.srch = (s.srch & ~(rx_addr_valid_i & (rx_addr_i == s.station)))
            | (wr_rxc & wdata_i[RXC_ADDR_SEARCH]);
        abort_ok = s.armed & ~s.srch;
        // A zero wins: in its cycle the detector outputs still describe older bits
        if (is_loop) begin
            next_s.abga = ~det_zero & (s.abga | det_ga | det_abort);
        end else begin
            next_s.abga = abort_ok & det_abort;
        end

        // Underrun / end of message
        eom_set = ~rst_b_i | send_abort_i | tx_off | (tx_underrun_i & ~s.end_of_message);
        eom_clr = cmd_eom | (is_bop & s.first_wr & tx_data_write_i);
        next_s.end_of_message = (s.end_of_message & ~eom_clr) | eom_set;
        next_s.crc = tx_underrun_i & ~s.end_of_message & s.mode[LM_CRC_EN];
        next_s.first_wr = (s.first_wr & ~tx_data_write_i) | tx_on;

        // Hunt: receiver off or enter-hunt beats a same-cycle sync detect
        next_s.hunt = (s.hunt & ~(sync_det_i | (is_bop & det_flag)))
            | rx_off | (wr_rxc & wdata_i[RXC_ENTER_HUNT]);

        next_s.allsent = is_async & tx_en_new & tx_buf_empty_i & tx_shift_empty_i
            & ~tx_data_write_i;

        // Baud zero latches; forced low while their enable is clear
        if (!s.ie[B_BRG]) begin
            next_s.txz = 1'b0;
            next_s.rxz = 1'b0;
        end else begin
            next_s.txz = (s.txz & ~cmd_latch) | transmit_baud_generator_zero_i;
            next_s.rxz = (s.rxz & ~cmd_latch) | receive_baud_generator_zero_i;
        end

        // Per-bit latch: a frozen bit keeps showing the value it changed to
        trig = (RISE_ONLY_MASK & cur & ~s.held) | (~RISE_ONLY_MASK & (cur ^ s.held));
        base_frz = s.frozen & ~{8{cmd_latch}} & latch_en;
        next_s.frozen = base_frz | (~base_frz & latch_en & trig);
        next_s.held = (base_frz & s.held) | (~base_frz & cur);
        next_s.pend = (s.pend & ~cmd_latch) | (|(~base_frz & latch_en & trig));

        next_s.rdata = RESET_BYTE;
        if (rd_i) begin
            case (addr_i)
                OFF_EXT_STATUS_FLAGS: next_s.rdata = shown;
                OFF_INTERRUPT_VECTOR_STATUS: next_s.rdata = vec;
                OFF_BAUD_ZERO_AND_RESIDUE: next_s.rdata = {3'h0, s.txz, s.rxz, 3'h0};
                OFF_INTERRUPT_MODE_CONTROL: next_s.rdata = {7'h00, s.master};
                OFF_STATUS_INTERRUPT_ENABLES: next_s.rdata = s.ie;
                OFF_RECEIVE_CONTROL: next_s.rdata = s.rxctl;
                OFF_STATION_ADDRESS: next_s.rdata = s.station;
                OFF_CLOCK_SOURCE_CONTROL: next_s.rdata = {s.crystal, 7'h00};
                OFF_VECTOR_MODE_CONTROL: next_s.rdata = s.vmode;
                OFF_PROGRAMMED_VECTOR: next_s.rdata = s.pvec;
                OFF_LINE_MODE: next_s.rdata = s.mode;
                default: next_s.rdata = RESET_BYTE;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s <= '0;
            s.end_of_message <= 1'b1;
            s.hunt <= 1'b1;
            s.held <= 8'h40;
        end else begin
            s <= next_s;
        end
    end

    // --------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------
    // A break is checked both as state and in the arriving cycle, so no null slips out
    assign rx_data_valid_o = rx_char_valid_i & ~(is_async & (s.brk | rx_break_char_i));
    assign rdata_o = s.rdata;
    assign tx_send_crc_o = s.crc;
    assign es_int_o = s.pend;

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    sequence s_cts_change;
        latch_en[B_CTS] && !s.frozen[B_CTS] && (cur[B_CTS] != s.held[B_CTS]);
    endsequence

    sequence s_cts_frozen;
        s.pend && s.frozen[B_CTS];
    endsequence

    a_cts_latch_raise: assert property (s_cts_change |=> s_cts_frozen)
        else $error("Clear-to-send change did not latch and interrupt");

    a_cts_follow_pin: assert property (!s.master ##1 !s.master |-> shown[B_CTS] == !cts_b_i)
        else $error("Disabled clear-to-send bit does not follow the pin");

    a_eom_cmd_clear: assert property (
        (cmd_eom && !send_abort_i && !tx_off && !tx_underrun_i) |=> !s.end_of_message)
        else $error("Reset end-of-message command did not clear the bit");

    a_eom_abort_set: assert property (send_abort_i |=> s.end_of_message)
        else $error("Send abort did not set end-of-message");

    a_crc_on_underrun: assert property (
        (tx_underrun_i && !s.end_of_message && s.mode[LM_CRC_EN]) |=> tx_send_crc_o && s.end_of_message)
        else $error("Underrun did not send CRC and set the bit");

    a_vec_plain_pass: assert property (!s.vmode[VMC_STATUS_VEC] |-> vec == s.pvec)
        else $error("Vector altered with status-modifies-vector off");

    a_vec_typeb_keep: assert property (
        (s.vmode[VMC_STATUS_VEC] && s.vmode[VMC_TYPE_B])
        |-> (vec[7:3] == s.pvec[7:3]) && (vec[2] == CHANNEL_A[0]))
        else $error("Type B vector upper bits or channel bit wrong");

    a_break_hides_null: assert property ((is_async && s.brk) |-> !rx_data_valid_o)
        else $error("Receive data passed during break");

    a_brg_gate_off: assert property (!s.ie[B_BRG] |=> !s.txz && !s.rxz)
        else $error("Baud zero bits set while enable clear");

    a_loop_zero_clear: assert property ((is_loop && det_zero) |=> !s.abga)
        else $error("Loop detect bit not cleared by a received zero");

    a_hunt_rx_off: assert property (rx_off |=> s.hunt)
        else $error("Receiver disable did not enter hunt");
endmodule

// ==== design/sesv_pkg.sv ====
// Constants, register map and field positions for the external status and vector block
package sesv_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 4;
    // --------------------------------------------------------------
    // Register offsets
    // --------------------------------------------------------------
    localparam logic [3:0] OFF_EXT_STATUS_FLAGS = 4'h0;
    localparam logic [3:0] OFF_INTERRUPT_VECTOR_STATUS = 4'h1;
    localparam logic [3:0] OFF_BAUD_ZERO_AND_RESIDUE = 4'h2;
    localparam logic [3:0] OFF_INTERRUPT_MODE_CONTROL = 4'h3;
    localparam logic [3:0] OFF_STATUS_INTERRUPT_ENABLES = 4'h4;
    localparam logic [3:0] OFF_RECEIVE_CONTROL = 4'h5;
    localparam logic [3:0] OFF_STATION_ADDRESS = 4'h6;
    localparam logic [3:0] OFF_COMMAND_CONTROL = 4'h7;
    localparam logic [3:0] OFF_CLOCK_SOURCE_CONTROL = 4'h8;
    localparam logic [3:0] OFF_VECTOR_MODE_CONTROL = 4'h9;
    localparam logic [3:0] OFF_PROGRAMMED_VECTOR = 4'hA;
    localparam logic [3:0] OFF_LINE_MODE = 4'hB;
    // --------------------------------------------------------------
    // Field positions
    // --------------------------------------------------------------
    localparam int B_BRK = 7;
    localparam int B_EOM = 6;
    localparam int B_CTS = 5;
    localparam int B_SYNC = 4;
    localparam int B_DCD = 3;
    localparam int B_ALLSENT = 2;
    localparam int B_IDLE = 1;
    localparam int B_BRG = 0;
    localparam int IMC_MASTER = 0;
    localparam int RXC_ENABLE = 0;
    localparam int RXC_ADDR_SEARCH = 2;
    localparam int RXC_ENTER_HUNT = 4;
    localparam int CSC_CRYSTAL = 7;
    localparam int VMC_STATUS_VEC = 6;
    localparam int VMC_TYPE_B = 5;
    localparam int LM_EXT_SYNC = 2;
    localparam int LM_LOOP = 3;
    localparam int LM_TX_EN = 4;
    localparam int LM_CRC_EN = 5;
    localparam int RES_TXZ = 4;
    localparam int RES_RXZ = 3;
    // Bits whose only interrupting change is a rise
    localparam logic [7:0] RISE_ONLY_MASK = 8'h45;
    // --------------------------------------------------------------
    // Modes, commands, cause codes, reset values
    // --------------------------------------------------------------
    localparam logic [1:0] MODE_ASYNC = 2'h0;
    localparam logic [1:0] MODE_COP = 2'h1;
    localparam logic [1:0] MODE_BOP = 2'h2;
    localparam logic [1:0] CMD_RESET_EOM = 2'h3;
    localparam logic [2:0] CMD_RESET_LATCH = 3'h2;
    localparam logic [1:0] CAUSE_TX_EMPTY = 2'h0;
    localparam logic [1:0] CAUSE_EXT_STATUS = 2'h1;
    localparam logic [1:0] CAUSE_RX_AVAIL = 2'h2;
    localparam logic [1:0] CAUSE_SPECIAL_RX = 2'h3;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] PATTERN_FLAG = 8'h7E;
    localparam logic [7:0] PATTERN_GO_AHEAD = 8'h7F;
    localparam int ABORT_RUN = 7;
    localparam int IDLE_RUN = 15;
endpackage

// ==== design/sesv_run_det.sv ====
// Receive bit stream pattern and run-of-ones detector
`timescale 1ns/1ps
module sesv_run_det #(
    parameter int RUN_W = 4
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic bit_valid_i,
    input wire logic bit_i,
    output logic abort_o,
    output logic idle_o,
    output logic flag_o,
    output logic ga_o,
    output logic zero_o
);
    import sesv_pkg::*;

    initial begin
        if (RUN_W < 4) begin
            $error("Run counter too narrow for the idle threshold");
        end
    end

    typedef struct packed {
        logic [RUN_W-1:0] run;
        logic [7:0] shreg;
        logic flag;
        logic ga;
    } sesv_det_s;

    sesv_det_s s;
    sesv_det_s next_s;
    logic [7:0] next_shreg;

    always_comb begin
        next_s = s;
        next_shreg = {s.shreg[6:0], bit_i};
        next_s.flag = 1'b0;
        next_s.ga = 1'b0;
        if (bit_valid_i) begin
            next_s.shreg = next_shreg;
            next_s.flag = (next_shreg == PATTERN_FLAG);
            next_s.ga = (next_shreg == PATTERN_GO_AHEAD);
            // Saturate so a long idle line never wraps back under the thresholds
            if (!bit_i) begin
                next_s.run = '0;
            end else if (s.run != '1) begin
                next_s.run = s.run + RUN_W'(1);
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign abort_o = (s.run >= RUN_W'(ABORT_RUN));
    assign idle_o = (s.run >= RUN_W'(IDLE_RUN));
    assign flag_o = s.flag;
    assign ga_o = s.ga;
    assign zero_o = bit_valid_i & ~bit_i;
endmodule

// ==== tb/sesv_host.sv ====
// Host processor model that drives the register port
`timescale 1ns/1ps
module sesv_host (
    input wire logic clk_i,
    output logic [sesv_pkg::ADDR_W-1:0] addr_o,
    output logic [sesv_pkg::DATA_W-1:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    import sesv_pkg::*;
    initial begin
        addr_o = 4'h0;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // ----------------------------------------
    // Bus cycles
    // ----------------------------------------
    // One strobe cycle, then a gap, so a strobe is never set twice in a step
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= w;
        rd_o <= !w;
        @(posedge clk_i);
        wr_o <= 1'b0;
        rd_o <= 1'b0;
    endtask
    // Called only after tx enable and one data write, so underrun sends the CRC
    task automatic clear_eom();
        bus(1'b1, OFF_COMMAND_CONTROL, 8'hC0);
    endtask
endmodule

// ==== tb/tb_sesv_top.sv ====
// Self-checking bench for the external status and vector block
`timescale 1ns/1ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin fails++; \
    $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module tb_sesv_top;
    import sesv_pkg::*;
    logic clk_i = 0, rst_b_i = 0, cts_b = 1, dcd_b = 1, sync_b = 1, rbv = 0, rbit = 0;
    logic rcv = 0, rbrk = 0, rav = 0, sdet = 0, txw = 0, tbe = 0, tse = 0, tun = 0;
    logic sab = 0, tz = 0, rz = 0, tei = 0, rai = 0, sri = 0, rdv, crc, esi, rd_d = 0;
    logic [7:0] ra = 0, wdata, rdata, v, exp_v;
    logic [3:0] addr;
    logic wr, rd;
    int fails = 0, total_checks = 0, crc_seen = 0, seed = 32'h686eee14;
    logic [7:0] expq[$];
    sesv_host h (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
    sesv_top uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .cts_b_i(cts_b), .dcd_b_i(dcd_b),
        .sync_b_i(sync_b), .rx_bit_valid_i(rbv), .rx_bit_i(rbit), .rx_char_valid_i(rcv),
        .rx_break_char_i(rbrk), .rx_addr_valid_i(rav), .rx_addr_i(ra), .sync_det_i(sdet),
        .tx_data_write_i(txw), .tx_buf_empty_i(tbe), .tx_shift_empty_i(tse),
        .tx_underrun_i(tun), .send_abort_i(sab), .transmit_baud_generator_zero_i(tz), .receive_baud_generator_zero_i(rz),
        .tx_empty_int_i(tei), .rx_avail_int_i(rai), .special_rx_int_i(sri),
        .rx_data_valid_o(rdv), .tx_send_crc_o(crc), .es_int_o(esi));
    // ----------------------------------------
    // Clock, watcher, tasks
    // ----------------------------------------
    initial forever #5 clk_i = ~clk_i;
    // Read data stand one cycle only, so the note is taken at that very edge
    always @(posedge clk_i) begin
        rd_d <= rd;
        if (crc === 1'b1) crc_seen++;
        if (rd_d === 1'b1) begin
            exp_v = expq.pop_front();
            `CHK("rdata", exp_v, rdata)
        end
    end
    task automatic rdx(input logic [3:0] a, input logic [7:0] e);
        expq.push_back(e);
        h.bus(1'b0, a, 8'h00);
    endtask
    task automatic wrx(input logic [3:0] a, input logic [7:0] d);
        h.bus(1'b1, a, d);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic rxb(input int n, input logic b);
        repeat (n) begin
            @(posedge clk_i) rbv <= 1;
            rbit <= b;
        end
        @(posedge clk_i) rbv <= 0;
    endtask
    task automatic close_out();
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #50000;
        fails++;
        close_out();
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        tick(8);
        rst_b_i <= 1;
        rdx(4'h0, 8'h40);
        rdx(4'h1, 8'h00);
        rdx(4'hF, 8'h00);
        wrx(4'h0, 8'hFF);
        rdx(4'h0, 8'h40);
        wrx(4'h3, 8'h01);
        wrx(4'h4, 8'h20);
        @(posedge clk_i) cts_b <= 0;
        tick(3);
        @(negedge clk_i) `CHK("es_int", 1'b1, esi)
        rdx(4'h0, 8'h60);
        @(posedge clk_i) cts_b <= 1;
        tick(3);
        rdx(4'h0, 8'h60);
        // The pin went back while frozen, so releasing the latch catches that change
        wrx(4'h7, 8'h10);
        tick(1);
        @(negedge clk_i) `CHK("es_int", 1'b1, esi)
        rdx(4'h0, 8'h40);
        wrx(4'h7, 8'h10);
        @(negedge clk_i) `CHK("es_int", 1'b0, esi)
        wrx(4'h4, 8'h00);
        @(posedge clk_i) dcd_b <= 0;
        tick(3);
        rdx(4'h0, 8'h48);
        @(negedge clk_i) `CHK("es_int", 1'b0, esi)
        @(posedge clk_i) dcd_b <= 1;
        // Crystal selected: the sync pin shows but never latches
        wrx(4'h8, 8'h80);
        wrx(4'h4, 8'h10);
        @(posedge clk_i) sync_b <= 0;
        tick(3);
        @(negedge clk_i) `CHK("es_int", 1'b0, esi)
        rdx(4'h0, 8'h50);
        @(posedge clk_i) sync_b <= 1;
        wrx(4'h4, 8'h80);
        @(posedge clk_i) rbrk <= 1;
        @(posedge clk_i) rbrk <= 0;
        rcv <= 1;
        @(negedge clk_i) `CHK("rx_valid", 1'b0, rdv)
        @(posedge clk_i) rcv <= 0;
        tick(2);
        rdx(4'h0, 8'hC0);
        @(negedge clk_i) `CHK("es_int", 1'b1, esi)
        v = $random(seed);
        wrx(4'hA, v);
        rdx(4'h1, v);
        @(posedge clk_i) sri <= 1;
        wrx(4'h9, 8'h40);
        rdx(4'h1, {v[7:5], 3'b111, v[1:0]});
        wrx(4'h9, 8'h60);
        // Status cause stays pending until c reaches zero
        for (int c = 3; c >= 0; c--) begin
            @(posedge clk_i);
            sri <= (c == 3);
            rai <= (c == 2);
            tei <= (c == 0);
            if (c == 0) wrx(4'h7, 8'h10);
            rdx(4'h1, {v[7:3], 1'b1, c[1:0]});
        end
        wrx(4'h4, 8'h00);
        @(posedge clk_i) rbv <= 1;
        rbit <= 1;
        @(posedge clk_i) rbv <= 0;
        tick(2);
        rdx(4'h0, 8'h40);
        wrx(4'hB, 8'h30);
        @(posedge clk_i) txw <= 1;
        @(posedge clk_i) txw <= 0;
        h.clear_eom();
        rdx(4'h0, 8'h00);
        wrx(4'h4, 8'h40);
        @(posedge clk_i) tun <= 1;
        @(posedge clk_i) tun <= 0;
        tick(2);
        `CHK("crc_pulses", 1, crc_seen)
        rdx(4'h0, 8'h40);
        @(negedge clk_i) `CHK("es_int", 1'b1, esi)
        wrx(4'h7, 8'h10);
        h.clear_eom();
        tick(1);
        @(negedge clk_i) `CHK("es_int", 1'b0, esi)
        @(posedge clk_i) sab <= 1;
        @(posedge clk_i) sab <= 0;
        tick(2);
        rdx(4'h0, 8'h40);
        @(negedge clk_i) `CHK("es_int", 1'b1, esi)
        wrx(4'h7, 8'h10);
        @(posedge clk_i) tbe <= 1;
        tse <= 1;
        tick(3);
        rdx(4'h0, 8'h44);
        wrx(4'hB, 8'h00);
        rdx(4'h0, 8'h40);
        wrx(4'hB, 8'h32);
        @(posedge clk_i) txw <= 1;
        @(posedge clk_i) txw <= 0;
        tick(2);
        @(negedge clk_i) `CHK("es_int", 1'b0, esi)
        @(posedge clk_i) tun <= 1;
        @(posedge clk_i) tun <= 0;
        tick(2);
        `CHK("crc_pulses", 2, crc_seen)
        wrx(4'h7, 8'h10);
        wrx(4'h4, 8'h01);
        @(posedge clk_i) tz <= 1;
        @(posedge clk_i) tz <= 0;
        tick(2);
        rdx(4'h2, 8'h10);
        @(negedge clk_i) `CHK("es_int", 1'b1, esi)
        wrx(4'h7, 8'h10);
        rdx(4'h2, 8'h00);
        // Bit-oriented receive: no abort before the opening flag
        wrx(4'h4, 8'h80);
        wrx(4'h5, 8'h01);
        rxb(8, 1'b1);
        rdx(4'h0, 8'h50);
        rxb(1, 1'b0);
        rxb(6, 1'b1);
        rxb(1, 1'b0);
        rxb(7, 1'b1);
        rdx(4'h0, 8'hC0);
        @(negedge clk_i) `CHK("es_int", 1'b1, esi)
        rxb(8, 1'b1);
        rdx(4'h0, 8'hC2);
        wrx(4'h7, 8'h10);
        rxb(1, 1'b0);
        rdx(4'h0, 8'h40);
        @(negedge clk_i) `CHK("es_int", 1'b1, esi)
        wrx(4'h7, 8'h10);
        // Address search hides the abort until the station address matches
        wrx(4'h5, 8'h05);
        wrx(4'h6, 8'h5A);
        rxb(7, 1'b1);
        rdx(4'h0, 8'h40);
        @(posedge clk_i) rav <= 1;
        ra <= 8'hA5;
        @(posedge clk_i) ra <= 8'h5A;
        @(posedge clk_i) rav <= 0;
        tick(2);
        rdx(4'h0, 8'hC0);
        wrx(4'h7, 8'h10);
        // Loop mode: a zero clears the bit, the go-ahead sets it again
        wrx(4'hB, 8'h3A);
        rxb(1, 1'b0);
        rdx(4'h0, 8'h40);
        wrx(4'h7, 8'h10);
        rxb(7, 1'b1);
        rdx(4'h0, 8'hC0);
        @(negedge clk_i) `CHK("es_int", 1'b1, esi)
        wrx(4'h7, 8'h10);
        wrx(4'h5, 8'h00);
        rdx(4'h0, 8'hD0);
        @(posedge clk_i) sdet <= 1;
        @(posedge clk_i) sdet <= 0;
        rdx(4'h0, 8'hC0);
        tick(3);
        close_out();
    end
endmodule
